/* hdl/lam_pkg.sv */
// Package: constants, types and register map for the line alarm monitor
// What this block does
// - Flag code violation when two successive bipolar violations share polarity.
// - Each violation drives the violation pin high one receive clock cycle.
// - Code-violation check needs codec enable, E1 mode and its select bit.
// - Flag zero-run violation on four or more consecutive zeros.
// - Zero-run check needs codec enable, E1 mode and its select bit.
// - Bipolar, code and zero-run violations share the violation pin.
// - Loss counter counts zeros, clears on ones; threshold sets loss, selects master clock.
// - Loss threshold 175 in T1, 32 in E1, 2048 when long threshold set.
// - T1 exit: 16 ones in 128-bit window, no 100-zero run; recovered clock returns.
// - E1 exit: four ones in 32 bits, under 16 zeros; or 32 consecutive ones.
// - During loss, data keeps flowing and an interrupt can be raised.
// - All-ones alarm when 2048 bits hold under three zeros; cleared at three.
// - Each all-ones alarm change sets its transition bit and may interrupt.
// - Driver open shown in status, changes recorded; clear bit clears or masks.
// - Elastic store near overflow or underflow shifts output clock one eighth bit.
// - Elastic overflow/underflow flags sticky until read; clear bits mask them.
// - Upper four bits of attenuation status report line attenuation estimate.
// - Self test: pattern lock sets interrupt, pattern change, sync and pass bits.
// - Host port detects which multiplexed bus timing style is used.
// - Interrupt latched low on enabled status change or elastic store slip.
// - Interrupt releases when clear written, even while condition persists; one masks, zero enables.
// - All control and status registers return to zero at reset.
// - Address decode uses only address bits six through one.
package lam_pkg;

  // ----------------------------------------------------------------
  // Register indices (address bits six to one)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CR1 = 6'h10;
  localparam logic [5:0] IDX_CR2 = 6'h11;
  localparam logic [5:0] IDX_CR3 = 6'h12;
  localparam logic [5:0] IDX_ICR = 6'h13;
  localparam logic [5:0] IDX_TSR = 6'h14;
  localparam logic [5:0] IDX_PSR = 6'h15;
  localparam logic [5:0] IDX_ESR = 6'h16;
  localparam logic [5:0] IDX_CR4 = 6'h17;
  localparam int ADDR_LO = 1;
  localparam int ADDR_HI = 6;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CR1_CODEC = 5;
  localparam int CR1_MODE_LO = 0;
  localparam int CR3_SELFTEST = 5;
  localparam int CR4_CODE_VIOLATION_SELECT = 0;
  localparam int CR4_ZERO_RUN_VIOLATION_SELECT = 1;
  localparam int CR4_LONG = 2;
  localparam int CR4_ALTEXIT = 3;
  localparam int BIT_LOS = 0;
  localparam int BIT_AIS = 2;
  localparam int BIT_PSEUDORANDOM_PATTERN_SYNC = 3;
  localparam int BIT_DRIVER_OPEN_FLAG = 5;
  localparam int BIT_BIST = 6;
  localparam int BIT_ESO = 6;
  localparam int BIT_ESU = 7;
  localparam int LATN_LO = 4;

  // ----------------------------------------------------------------
  // Mode codes and counts
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_E1_A = 4'h8;
  localparam logic [3:0] MODE_E1_A_MASK = 4'hE;
  localparam logic [3:0] MODE_E1_B = 4'hA;
  localparam int LOS_T1 = 175;
  localparam int LOS_E1 = 32;
  localparam int LOS_LONG = 2048;
  localparam int T1_WIN = 128;
  localparam int T1_ONES = 16;
  localparam int T1_ZRUN = 100;
  localparam int E1_WIN = 32;
  localparam int E1_ONES = 4;
  localparam int E1_ZRUN = 16;
  localparam int E1_MARKS = 32;
  localparam int ZERO_RUN_VIOLATION_SELECT_RUN = 4;
  localparam int AIS_SPAN = 2048;
  localparam int AIS_ZEROS = 3;
  localparam int CNT_W = 12;

  // Received symbol from the line decoder
  typedef struct packed {
    logic valid;
    logic mark;
    logic bpv;
    logic polarity;
  } lam_rx_type;

  // Host bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lam_bus_type;

  // Bus style detected on the host port
  typedef enum logic [1:0] {
    LAM_BUS_ALE = 2'b01,
    LAM_BUS_DS = 2'b10
  } lam_style_type;

endpackage : lam_pkg

/* hdl/lam_window.sv */
// Sliding window ones counter with a run-of-zeros tracker
`timescale 1ns/1ps
module lam_window #(
  parameter int WIN = 128,
  parameter int CW = 12
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic step,
  input wire logic mark,
  output logic [CW-1:0] ones,
  output logic [CW-1:0] zrun
);

  // ----------------------------------------------------------------
  // History shift register and counters
  // ----------------------------------------------------------------
  logic [WIN-1:0] hist_reg;
  logic [WIN-1:0] hist_next;
  logic [CW-1:0] ones_reg;
  logic [CW-1:0] ones_next;
  logic [CW-1:0] zrun_reg;
  logic [CW-1:0] zrun_next;

  always_comb begin
    hist_next = hist_reg;
    ones_next = ones_reg;
    zrun_next = zrun_reg;
    if (step) begin
      hist_next = {hist_reg[WIN-2:0], mark};
      ones_next = ones_reg + CW'(mark) - CW'(hist_reg[WIN-1]);
      if (mark) begin
        zrun_next = '0;
      end else if (zrun_reg != {CW{1'b1}}) begin
        zrun_next = zrun_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hist_reg <= '0;
      ones_reg <= '0;
      zrun_reg <= '0;
    end else if (ce) begin
      hist_reg <= hist_next;
      ones_reg <= ones_next;
      zrun_reg <= zrun_next;
    end
  end

  assign ones = ones_reg;
  assign zrun = zrun_reg;

endmodule : lam_window

/* hdl/lam_monitor.sv */
// Receive alarm monitor with status registers and host interrupt
`timescale 1ns/1ps
module lam_monitor #(
  parameter int LOS_T1_N = lam_pkg::LOS_T1,
  parameter int LOS_E1_N = lam_pkg::LOS_E1,
  parameter int LOS_LONG_N = lam_pkg::LOS_LONG,
  parameter int AIS_N = lam_pkg::AIS_SPAN
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire lam_pkg::lam_rx_type rx_in,
  input wire logic driver_open_in,
  input wire logic elastic_near_full_in,
  input wire logic elastic_near_empty_in,
  input wire logic elastic_over_in,
  input wire logic elastic_under_in,
  input wire logic [3:0] attenuation_in,
  input wire logic pattern_lock_in,
  input wire logic ale_in,
  input wire lam_pkg::lam_bus_type bus_in,
  output logic [7:0] rdata,
  output logic violation_out,
  output logic use_master_clk,
  output logic clk_phase_shift,
  output logic [1:0] shift_dir,
  output logic int_n,
  output logic bus_style_ale,
  output logic [7:0] control_reg_one_out,
  output logic [7:0] control_reg_three_out
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] control_reg_one_reg, control_reg_one_next;
  logic [7:0] control_reg_two_reg, control_reg_two_next;
  logic [7:0] control_reg_three_reg, control_reg_three_next;
  logic [7:0] control_reg_four_reg, control_reg_four_next;
  logic [7:0] interrupt_clear_reg, interrupt_clear_next;
  logic [7:0] transition_status_reg, transition_status_next;
  logic [7:0] performance_status_reg, performance_status_next;
  logic [7:0] status_prev_reg, status_prev_next;
  logic [7:0] rdata_reg, rdata_next;
  logic violation_reg, violation_next;
  logic int_n_reg, int_n_next;
  logic shift_reg, shift_next;
  logic [1:0] dir_reg, dir_next;
  logic last_pol_reg, last_pol_next;
  logic have_bpv_reg, have_bpv_next;
  logic [lam_pkg::CNT_W-1:0] loss_cnt_reg, loss_cnt_next;
  logic [lam_pkg::CNT_W-1:0] ais_bits_reg, ais_bits_next;
  logic [1:0] ais_zeros_reg, ais_zeros_next;
  lam_pkg::lam_style_type style_reg, style_next;

  logic [lam_pkg::CNT_W-1:0] t1_ones, t1_zrun, e1_ones, e1_zrun;
  logic step;
  logic e1_mode;
  logic [5:0] idx;

  // Mode code decode used by both violation checks
  function automatic logic is_e1(input logic [3:0] code);
    return ((code & lam_pkg::MODE_E1_A_MASK) == lam_pkg::MODE_E1_A) ||
           (code == lam_pkg::MODE_E1_B);
  endfunction : is_e1

  assign step = rx_in.valid;
  assign e1_mode = is_e1(control_reg_one_reg[lam_pkg::CR1_MODE_LO +: 4]);
  assign idx = bus_in.addr[lam_pkg::ADDR_HI:lam_pkg::ADDR_LO];

  // ----------------------------------------------------------------
  // Loss exit windows
  // ----------------------------------------------------------------
  lam_window #(.WIN(lam_pkg::T1_WIN), .CW(lam_pkg::CNT_W)) u_t1_win (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .step(step),
    .mark(rx_in.mark),
    .ones(t1_ones),
    .zrun(t1_zrun)
  );

  lam_window #(.WIN(lam_pkg::E1_WIN), .CW(lam_pkg::CNT_W)) u_e1_win (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .step(step),
    .mark(rx_in.mark),
    .ones(e1_ones),
    .zrun(e1_zrun)
  );

  // ----------------------------------------------------------------
  // Line monitoring
  // ----------------------------------------------------------------
  logic codec_on, cv_on, zv_on, cv_hit, zv_hit, bpv_rep;
  logic [lam_pkg::CNT_W-1:0] loss_limit;
  logic exit_t1, exit_e1, los_now;

  always_comb begin
    codec_on = control_reg_one_reg[lam_pkg::CR1_CODEC];
    cv_on = codec_on && e1_mode && control_reg_four_reg[lam_pkg::CR4_CODE_VIOLATION_SELECT];
    zv_on = codec_on && e1_mode && control_reg_four_reg[lam_pkg::CR4_ZERO_RUN_VIOLATION_SELECT];
    cv_hit = cv_on && step && rx_in.bpv && have_bpv_reg && (rx_in.polarity == last_pol_reg);
    zv_hit = zv_on && step && !rx_in.mark &&
             (e1_zrun >= lam_pkg::CNT_W'(lam_pkg::ZERO_RUN_VIOLATION_SELECT_RUN - 1));
    bpv_rep = step && rx_in.bpv && !codec_on;
    // All sources share one pin, one cycle each
    violation_next = cv_hit || zv_hit || bpv_rep;
    have_bpv_next = have_bpv_reg || (step && rx_in.bpv);
    last_pol_next = (step && rx_in.bpv) ? rx_in.polarity : last_pol_reg;

    if (control_reg_four_reg[lam_pkg::CR4_LONG]) begin
      loss_limit = lam_pkg::CNT_W'(LOS_LONG_N);
    end else if (e1_mode) begin
      loss_limit = lam_pkg::CNT_W'(LOS_E1_N);
    end else begin
      loss_limit = lam_pkg::CNT_W'(LOS_T1_N);
    end
    // Zero counter cleared by a mark
    loss_cnt_next = loss_cnt_reg;
    if (step) begin
      if (rx_in.mark) begin
        loss_cnt_next = '0;
      end else if (loss_cnt_reg < loss_limit) begin
        loss_cnt_next = loss_cnt_reg + lam_pkg::CNT_W'(1);
      end
    end
    exit_t1 = (t1_ones >= lam_pkg::CNT_W'(lam_pkg::T1_ONES)) &&
              (t1_zrun < lam_pkg::CNT_W'(lam_pkg::T1_ZRUN));
    // E1 exit criterion or consecutive marks
    if (control_reg_four_reg[lam_pkg::CR4_ALTEXIT]) begin
      exit_e1 = e1_ones == lam_pkg::CNT_W'(lam_pkg::E1_MARKS);
    end else begin
      exit_e1 = (e1_ones >= lam_pkg::CNT_W'(lam_pkg::E1_ONES)) &&
                (e1_zrun < lam_pkg::CNT_W'(lam_pkg::E1_ZRUN));
    end
    los_now = performance_status_reg[lam_pkg::BIT_LOS];
    if (loss_cnt_next >= loss_limit) begin
      los_now = 1'b1;
    end else if (los_now && (e1_mode ? exit_e1 : exit_t1)) begin
      los_now = 1'b0;
    end

    // Count zeros over each 2048-bit span
    ais_bits_next = ais_bits_reg;
    ais_zeros_next = ais_zeros_reg;
    performance_status_next = performance_status_reg;
    performance_status_next[lam_pkg::BIT_LOS] = los_now;
    if (step) begin
      if (ais_bits_reg == lam_pkg::CNT_W'(AIS_N - 1)) begin
        // Three-bit sum: a saturated count plus a final zero must not wrap
        performance_status_next[lam_pkg::BIT_AIS] =
          (3'(ais_zeros_reg) + 3'(!rx_in.mark)) < 3'(lam_pkg::AIS_ZEROS);
        ais_bits_next = '0;
        ais_zeros_next = '0;
      end else begin
        ais_bits_next = ais_bits_reg + lam_pkg::CNT_W'(1);
        if (!rx_in.mark && ais_zeros_reg != 2'(lam_pkg::AIS_ZEROS)) begin
          ais_zeros_next = ais_zeros_reg + 2'(1);
        end
      end
    end
    performance_status_next[lam_pkg::BIT_DRIVER_OPEN_FLAG] = driver_open_in;
    // Self test pass and pattern sync
    performance_status_next[lam_pkg::BIT_PSEUDORANDOM_PATTERN_SYNC] = pattern_lock_in;
    performance_status_next[lam_pkg::BIT_BIST] =
      pattern_lock_in && control_reg_three_reg[lam_pkg::CR3_SELFTEST];
    // Eighth-bit clock slip near elastic store limits
    shift_next = elastic_near_full_in || elastic_near_empty_in;
    dir_next = {elastic_near_empty_in, elastic_near_full_in};
  end

  // ----------------------------------------------------------------
  // Host port, transitions and interrupt
  // ----------------------------------------------------------------
  logic [7:0] changed, clear_w, pend;

  always_comb begin
    control_reg_one_next = control_reg_one_reg;
    control_reg_two_next = control_reg_two_reg;
    control_reg_three_next = control_reg_three_reg;
    control_reg_four_next = control_reg_four_reg;
    interrupt_clear_next = interrupt_clear_reg;
    rdata_next = rdata_reg;
    clear_w = 8'h00;
    // Address latch strobe marks the multiplexed style
    style_next = ale_in ? lam_pkg::LAM_BUS_ALE :
                 (bus_in.rd || bus_in.wr) && style_reg != lam_pkg::LAM_BUS_ALE ?
                 lam_pkg::LAM_BUS_DS : style_reg;
    if (bus_in.wr) begin
      unique case (idx)
        lam_pkg::IDX_CR1: control_reg_one_next = bus_in.wdata;
        lam_pkg::IDX_CR2: control_reg_two_next = bus_in.wdata;
        lam_pkg::IDX_CR3: control_reg_three_next = bus_in.wdata;
        lam_pkg::IDX_CR4: control_reg_four_next = bus_in.wdata;
        lam_pkg::IDX_ICR: begin
          interrupt_clear_next = bus_in.wdata;
          clear_w = bus_in.wdata;
        end
        default: ;
      endcase
    end
    if (bus_in.rd) begin
      unique case (idx)
        lam_pkg::IDX_CR1: rdata_next = control_reg_one_reg;
        lam_pkg::IDX_CR2: rdata_next = control_reg_two_reg;
        lam_pkg::IDX_CR3: rdata_next = control_reg_three_reg;
        lam_pkg::IDX_CR4: rdata_next = control_reg_four_reg;
        lam_pkg::IDX_ICR: rdata_next = interrupt_clear_reg;
        lam_pkg::IDX_TSR: rdata_next = transition_status_reg;
        lam_pkg::IDX_PSR: rdata_next = performance_status_reg;
        lam_pkg::IDX_ESR: rdata_next = {attenuation_in, 4'h0};
        default: rdata_next = 8'h00;
      endcase
    end
    status_prev_next = performance_status_reg;
    changed = performance_status_reg ^ status_prev_reg;
    changed[lam_pkg::BIT_ESO] = elastic_over_in;
    changed[lam_pkg::BIT_ESU] = elastic_under_in;
    changed[4] = 1'b0;
    transition_status_next = (transition_status_reg & ~clear_w) | changed;
    // Elastic flags clear when the host reads this register
    if (bus_in.rd && idx == lam_pkg::IDX_TSR) begin
      transition_status_next[lam_pkg::BIT_ESO] = changed[lam_pkg::BIT_ESO];
      transition_status_next[lam_pkg::BIT_ESU] = changed[lam_pkg::BIT_ESU];
    end
    // Latched interrupt on unmasked pending sources
    pend = transition_status_next & ~interrupt_clear_next;
    pend[4] = 1'b0;
    int_n_next = !(|pend);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      control_reg_one_reg <= lam_pkg::REG_RESET;
      control_reg_two_reg <= lam_pkg::REG_RESET;
      control_reg_three_reg <= lam_pkg::REG_RESET;
      control_reg_four_reg <= lam_pkg::REG_RESET;
      interrupt_clear_reg <= lam_pkg::REG_RESET;
      transition_status_reg <= lam_pkg::REG_RESET;
      performance_status_reg <= lam_pkg::REG_RESET;
      status_prev_reg <= lam_pkg::REG_RESET;
      rdata_reg <= lam_pkg::REG_RESET;
      violation_reg <= 1'b0;
      int_n_reg <= 1'b1;
      shift_reg <= 1'b0;
      dir_reg <= 2'b00;
      last_pol_reg <= 1'b0;
      have_bpv_reg <= 1'b0;
      loss_cnt_reg <= '0;
      ais_bits_reg <= '0;
      ais_zeros_reg <= '0;
      style_reg <= lam_pkg::LAM_BUS_DS;
    end else if (ce) begin
      control_reg_one_reg <= control_reg_one_next;
      control_reg_two_reg <= control_reg_two_next;
      control_reg_three_reg <= control_reg_three_next;
      control_reg_four_reg <= control_reg_four_next;
      interrupt_clear_reg <= interrupt_clear_next;
      transition_status_reg <= transition_status_next;
      performance_status_reg <= performance_status_next;
      status_prev_reg <= status_prev_next;
      rdata_reg <= rdata_next;
      violation_reg <= violation_next;
      int_n_reg <= int_n_next;
      shift_reg <= shift_next;
      dir_reg <= dir_next;
      last_pol_reg <= last_pol_next;
      have_bpv_reg <= have_bpv_next;
      loss_cnt_reg <= loss_cnt_next;
      ais_bits_reg <= ais_bits_next;
      ais_zeros_reg <= ais_zeros_next;
      style_reg <= style_next;
    end
  end

  assign rdata = rdata_reg;
  assign violation_out = violation_reg;
  assign use_master_clk = performance_status_reg[lam_pkg::BIT_LOS];
  assign clk_phase_shift = shift_reg;
  assign shift_dir = dir_reg;
  assign int_n = int_n_reg;
  assign bus_style_ale = (style_reg == lam_pkg::LAM_BUS_ALE);
  assign control_reg_one_out = control_reg_one_reg;
  assign control_reg_three_out = control_reg_three_reg;

endmodule : lam_monitor

/* verif/lam_monitor_sva.sv */
// Port checker for the line alarm monitor
`timescale 1ns/1ps
module lam_monitor_sva #(
  parameter int LOS_T1_N = 175,
  parameter int LOS_E1_N = 32,
  parameter int LOS_LONG_N = 2048,
  parameter int AIS_N = 2048
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire lam_pkg::lam_rx_type rx_in,
  input wire logic elastic_near_full_in,
  input wire logic elastic_near_empty_in,
  input wire logic [3:0] attenuation_in,
  input wire logic ale_in,
  input wire lam_pkg::lam_bus_type bus_in,
  input wire logic [7:0] rdata,
  input wire logic violation_out,
  input wire logic use_master_clk,
  input wire logic clk_phase_shift,
  input wire logic [1:0] shift_dir,
  input wire logic int_n,
  input wire logic bus_style_ale,
  input wire logic [7:0] control_reg_one_out
);
  default clocking cb @(posedge sys_clk); endclocking
  sequence rd_s(idx);
    ce && bus_in.rd && bus_in.addr[6:1] == idx;
  endsequence
  sequence wr_s(idx);
    ce && bus_in.wr && bus_in.addr[6:1] == idx;
  endsequence
  reset_state_a: assert property (rst |=> int_n && !violation_out && !use_master_clk
    && control_reg_one_out == 8'h00 && rdata == 8'h00) else $error("reset state wrong");
  viol_cause_a: assert property (disable iff (rst)
    violation_out && $past(ce) |-> $past(rx_in.valid)) else $error("violation without bit");
  raw_bpv_a: assert property (disable iff (rst)
    ce && rx_in.valid && rx_in.bpv && !control_reg_one_out[5] |=> violation_out)
    else $error("raw bipolar violation lost");
  loss_rise_a: assert property (disable iff (rst)
    $rose(use_master_clk) |-> $past(rx_in.valid && !rx_in.mark)) else $error("loss without zero");
  loss_fall_a: assert property (disable iff (rst)
    $fell(use_master_clk) |-> $past(rx_in.valid && rx_in.mark) ||
    $past(rx_in.valid && rx_in.mark, 2)) else $error("exit without mark");
  ctl_write_a: assert property (disable iff (rst)
    wr_s(lam_pkg::IDX_CR1) |=> control_reg_one_out == $past(bus_in.wdata))
    else $error("control write lost");
  atten_read_a: assert property (disable iff (rst)
    rd_s(lam_pkg::IDX_ESR) |=> rdata[7:4] == $past(attenuation_in)) else $error("attenuation wrong");
  unmapped_read_a: assert property (disable iff (rst)
    ce && bus_in.rd && bus_in.addr[6:4] != 3'b010 |=> rdata == 8'h00) else $error("unmapped data");
  shift_follow_a: assert property (disable iff (rst)
    ce |=> shift_dir == $past({elastic_near_empty_in, elastic_near_full_in})
    && clk_phase_shift == $past(elastic_near_empty_in || elastic_near_full_in))
    else $error("phase shift wrong");
  style_pick_a: assert property (disable iff (rst)
    ce && ale_in |=> bus_style_ale) else $error("bus style not taken");
endmodule : lam_monitor_sva
bind lam_monitor lam_monitor_sva #(.LOS_T1_N(LOS_T1_N), .LOS_E1_N(LOS_E1_N),
  .LOS_LONG_N(LOS_LONG_N), .AIS_N(AIS_N)) lam_monitor_sva_i (.sys_clk(sys_clk), .rst(rst),
  .ce(ce), .rx_in(rx_in), .elastic_near_full_in(elastic_near_full_in),
  .elastic_near_empty_in(elastic_near_empty_in), .attenuation_in(attenuation_in),
  .ale_in(ale_in), .bus_in(bus_in), .rdata(rdata), .violation_out(violation_out),
  .use_master_clk(use_master_clk), .clk_phase_shift(clk_phase_shift), .shift_dir(shift_dir),
  .int_n(int_n), .bus_style_ale(bus_style_ale), .control_reg_one_out(control_reg_one_out));

/* verif/lam_host.sv */
// Host processor model driving the register bus
`timescale 1ns/1ps
module lam_host (
  input wire logic sys_clk,
  input wire logic [7:0] rdata,
  output lam_pkg::lam_bus_type bus_in,
  output logic ale_in
);
  logic use_ale = 1'b0;
  initial begin
    bus_in = '0;
    ale_in = 1'b0;
  end
  // One access, then the bus goes back to a meaningless idle value
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    logic [7:0] dd;
    dd = d;
    if (w && a[6:1] == lam_pkg::IDX_ICR) dd[4] = 1'b1;
    bus_in = '{w, !w, a, dd};
    ale_in = use_ale;
    @(posedge sys_clk);
    #1;
    bus_in = '{1'b0, 1'b0, ~a, ~dd};
    ale_in = 1'b0;
    q = rdata;
    @(posedge sys_clk);
    #1;
  endtask : access
endmodule : lam_host

/* verif/line_alarm_monitor_irq_bench.sv */
// Self-checking bench for the line alarm monitor
`timescale 1ns/1ps
module line_alarm_monitor_irq_bench;
  localparam int E1N = 12;
  logic sys_clk, rst, ce, v, driver_open_in, elastic_near_full_in, elastic_near_empty_in;
  logic elastic_over_in, elastic_under_in, pattern_lock_in, ale_in, violation_out;
  logic use_master_clk, clk_phase_shift, int_n, bus_style_ale;
  logic [3:0] attenuation_in;
  logic [1:0] shift_dir;
  logic [7:0] rdata, q, c, d, cr3;
  lam_pkg::lam_rx_type rx_in;
  lam_pkg::lam_bus_type bus_in;
  logic [7:0] modes [6] = '{8'h28, 8'h29, 8'h2A, 8'h22, 8'h2B, 8'h08};
  int err_total = 0;
  int checks_done = 0;
  int seed = 19;
  lam_monitor #(.LOS_T1_N(20), .LOS_E1_N(E1N), .LOS_LONG_N(40), .AIS_N(64)) lam_monitor_i (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .rx_in(rx_in), .driver_open_in(driver_open_in),
    .elastic_near_full_in(elastic_near_full_in), .elastic_near_empty_in(elastic_near_empty_in),
    .elastic_over_in(elastic_over_in), .elastic_under_in(elastic_under_in),
    .attenuation_in(attenuation_in), .pattern_lock_in(pattern_lock_in), .ale_in(ale_in),
    .bus_in(bus_in), .rdata(rdata), .violation_out(violation_out),
    .use_master_clk(use_master_clk), .clk_phase_shift(clk_phase_shift), .shift_dir(shift_dir),
    .int_n(int_n), .bus_style_ale(bus_style_ale), .control_reg_one_out(),
    .control_reg_three_out(cr3));
  lam_host lam_host_i (.sys_clk(sys_clk), .rdata(rdata), .bus_in(bus_in), .ale_in(ale_in));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic e1(input logic [7:0] m);
    return m[5] && (m[3:1] == 3'b100 || m[3:0] == 4'hA);
  endfunction : e1
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic reg_io(input logic w, input logic [5:0] i, input logic [7:0] dv);
    logic [7:0] a;
    a = $random(seed);
    lam_host_i.access(w, {a[7], i, a[0]}, dv, q);
  endtask : reg_io
  task automatic bit_in(input logic m, input logic b, input logic p);
    rx_in = '{1'b1, m, b, p};
    {elastic_near_full_in, elastic_near_empty_in} = 2'($random(seed));
    @(posedge sys_clk);
    #1;
    v = violation_out;
    rx_in.valid = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : bit_in
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #100000;
    err_total++;
    close_out();
  end
  initial begin
    {rst, ce, driver_open_in, elastic_over_in, elastic_under_in, pattern_lock_in} = 6'h30;
    {elastic_near_full_in, elastic_near_empty_in, attenuation_in} = '0;
    rx_in = '0;
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    for (int i = 16; i < 24; i++) begin
      reg_io(1'b0, 6'(i), 8'h00);
      chk("register after reset", 8'h00, q);
    end
    chk("bus style", 8'h00, 8'(bus_style_ale));
    reg_io(1'b0, 6'h05, 8'h00);
    chk("unmapped read", 8'h00, q);
    repeat (4) begin
      d = $random(seed);
      attenuation_in = $random(seed);
      reg_io(1'b1, lam_pkg::IDX_CR1, d);
      reg_io(1'b0, lam_pkg::IDX_CR1, 8'h00);
      chk("control one", d, q);
      reg_io(1'b0, lam_pkg::IDX_ESR, 8'h00);
      chk("attenuation", {attenuation_in, 4'h0}, q & 8'hF0);
    end
    foreach (modes[k]) begin
      c = modes[k];
      reg_io(1'b1, lam_pkg::IDX_CR1, c);
      reg_io(1'b1, lam_pkg::IDX_CR4, 8'h01);
      bit_in(1'b1, 1'b1, 1'b0);
      bit_in(1'b1, 1'b1, 1'b1);
      chk("alternating violation", 8'(!c[5]), 8'(v));
      bit_in(1'b1, 1'b1, 1'b1);
      chk("code violation", 8'(!c[5] || e1(c)), 8'(v));
      reg_io(1'b1, lam_pkg::IDX_CR4, 8'h02);
      bit_in(1'b1, 1'b0, 1'b0);
      repeat (3) bit_in(1'b0, 1'b0, 1'b0);
      chk("three zeros", 8'h00, 8'(v));
      bit_in(1'b0, 1'b0, 1'b0);
      chk("zero run violation", 8'(e1(c)), 8'(v));
    end
    reg_io(1'b1, lam_pkg::IDX_CR1, 8'h28);
    reg_io(1'b1, lam_pkg::IDX_CR4, 8'h00);
    bit_in(1'b1, 1'b0, 1'b0);
    repeat (E1N - 1) bit_in(1'b0, 1'b0, 1'b0);
    chk("loss early", 8'h00, 8'(use_master_clk));
    bit_in(1'b0, 1'b0, 1'b0);
    chk("loss set", 8'h01, 8'(use_master_clk));
    reg_io(1'b0, lam_pkg::IDX_PSR, 8'h00);
    chk("loss status", 8'h01, q & 8'h01);
    reg_io(1'b0, lam_pkg::IDX_TSR, 8'h00);
    chk("loss change", 8'h01, q & 8'h01);
    chk("loss interrupt", 8'h00, 8'(int_n));
    repeat (20) bit_in(1'b0, 1'b0, 1'b0);
    repeat (4) begin
      chk("loss held", 8'h01, 8'(use_master_clk));
      bit_in(1'b1, 1'b0, 1'b0);
      repeat (7) bit_in(1'b0, 1'b0, 1'b0);
    end
    chk("loss exit", 8'h00, 8'(use_master_clk));
    reg_io(1'b1, lam_pkg::IDX_ICR, 8'h01);
    reg_io(1'b0, lam_pkg::IDX_TSR, 8'h00);
    chk("change cleared", 8'h00, q & 8'h01);
    chk("interrupt released", 8'h01, 8'(int_n));
    reg_io(1'b1, lam_pkg::IDX_ICR, 8'h00);
    elastic_over_in = 1'b1;
    @(posedge sys_clk);
    #1;
    elastic_over_in = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("overflow interrupt", 8'h00, 8'(int_n));
    reg_io(1'b0, lam_pkg::IDX_TSR, 8'h00);
    chk("overflow flag", 8'h40, q & 8'h40);
    reg_io(1'b0, lam_pkg::IDX_TSR, 8'h00);
    chk("overflow after read", 8'h00, q & 8'h40);
    chk("interrupt after read", 8'h01, 8'(int_n));
    reg_io(1'b1, lam_pkg::IDX_ICR, 8'h80);
    elastic_under_in = 1'b1;
    @(posedge sys_clk);
    #1;
    elastic_under_in = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("masked underflow", 8'h01, 8'(int_n));
    driver_open_in = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("driver open interrupt", 8'h00, 8'(int_n));
    reg_io(1'b0, lam_pkg::IDX_TSR, 8'h00);
    chk("driver open change", 8'h20, q & 8'h20);
    reg_io(1'b1, lam_pkg::IDX_ICR, 8'h20);
    chk("driver open cleared", 8'h01, 8'(int_n));
    reg_io(1'b1, lam_pkg::IDX_ICR, 8'h00);
    // Self test checked after the loss tests and before the all-ones bits; all-ones bits then driven with self test still on
    reg_io(1'b1, lam_pkg::IDX_CR3, 8'h20);
    chk("control three", 8'h20, cr3);
    pattern_lock_in = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("self test interrupt", 8'h00, 8'(int_n));
    reg_io(1'b0, lam_pkg::IDX_PSR, 8'h00);
    chk("self test status", 8'h68, q & 8'h68);
    reg_io(1'b0, lam_pkg::IDX_TSR, 8'h00);
    chk("pattern change", 8'h08, q & 8'h08);
    repeat (130) bit_in(1'b1, 1'b0, 1'b0);
    reg_io(1'b0, lam_pkg::IDX_PSR, 8'h00);
    chk("all ones alarm", 8'h04, q & 8'h04);
    reg_io(1'b0, lam_pkg::IDX_TSR, 8'h00);
    chk("all ones change", 8'h04, q & 8'h04);
    ce = 1'b0;
    reg_io(1'b1, lam_pkg::IDX_CR1, 8'h55);
    ce = 1'b1;
    lam_host_i.use_ale = 1'b1;
    reg_io(1'b0, lam_pkg::IDX_CR1, 8'h00);
    chk("frozen write", 8'h28, q);
    chk("bus style latch", 8'h01, 8'(bus_style_ale));
    close_out();
  end
endmodule : line_alarm_monitor_irq_bench
